// [common/pmc_defines.svh]
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH
// Overview of operation
// RULE1: Four user run modes, own clock sets.
// RULE2: Each run mode has its own configuration register.
// RULE3: Run mode switches finish within few cycles.
// RULE4: Reset enters default run mode, gateway to runs.
// RULE5: Boot assist runs only in default run mode.
// RULE6: Wait gates core clock, peripherals full speed.
// RULE7: Interrupt wakes core quickly from wait.
// RULE8: Halt gates core, peripherals normal or slow.
// RULE9: Halt may drop PLL, regulator, flash; slower wake.
// RULE10: Halt PLL follows configuration, default off.
// RULE11: Stop gates core, peripherals, forces PLL off.
// RULE12: Stop halts oscillator unless kept running.
// RULE13: Stop keeps real-time clock and wakeup timer; the code keeps each only while its stop_cfg bit is set.
// RULE14: Stop optionally keeps fast and slow RC.
// RULE15: Standby keeps lowest 8K or all RAM.
// RULE16: Software saves context before standby.
// RULE17: Standby exits on pin, timer or clock event.
// RULE18: Eighteen fixed wakeup pins enabled together; the code enables each pin by its own wake_en bit.
// RULE19: Enabled non-maskable interrupt locks its pin.
// RULE20: Three types; critical type blocked by enable.
// RULE21: Machine-check type unmaskable, not recoverable.
// RULE22: Held machine-check keeps interrupt asserted.
// RULE23: Mode commits only after resources confirmed stable.
// RULE24: Wakeup returns to configured mode; standby to default.

// Register byte offsets.
`define PMC_OFS_MODE_CTL 12'h000
`define PMC_OFS_MODE_STAT 12'h004
`define PMC_OFS_RUN_CFG0 12'h008
`define PMC_OFS_DEFAULT_RUN_MODE_CFG 12'h018
`define PMC_OFS_HALT_CFG 12'h01c
`define PMC_OFS_STOP_CFG 12'h020
`define PMC_OFS_STBY_CFG 12'h024
`define PMC_OFS_WAKE_EN 12'h028
`define PMC_OFS_WAKE_FLAG 12'h02c
`define PMC_OFS_NMI_CFG 12'h030
`define PMC_OFS_WAKE_RET 12'h034

// Mode codes.
`define PMC_MODE_DEFAULT_RUN_MODE 4'h0
`define PMC_MODE_RUN0 4'h1
`define PMC_MODE_RUN3 4'h4
`define PMC_MODE_WAIT 4'h5
`define PMC_MODE_HALT 4'h6
`define PMC_MODE_STOP 4'h7
`define PMC_MODE_STBY 4'h8

// Configuration word fields.
`define PMC_CFG_XOSC 0
`define PMC_CFG_FIRC 1
`define PMC_CFG_SIRC 2
`define PMC_CFG_PLL 3
`define PMC_CFG_FLASH 4
`define PMC_CFG_MREG 5
`define PMC_CFG_SLOW 6
`define PMC_CFG_PCLK_LO 8
`define PMC_CFG_RTC 16
`define PMC_CFG_PWT 17
`define PMC_CFG_RAM_ALL 18

// Control and status fields.
`define PMC_CTL_BOOT_DONE 8
`define PMC_STAT_BUSY 4
`define PMC_STAT_ERR 5
`define PMC_STAT_BOOT 6
`define PMC_NMI_CLR_HOLD 3
`define PMC_FLAG_PWT 18
`define PMC_FLAG_RTC 19

// Reset values.
`define PMC_RST_RUN_CFG 32'h0000_ff3f
`define PMC_RST_HALT_CFG 32'h0003_ff36
`define PMC_RST_STOP_CFG 32'h0003_0026
`define PMC_RST_STBY_CFG 32'h0003_0004
// Enables after reset: core, all peripherals, oscillators and supplies on; timers off.
`define PMC_RST_CTRL 20'hffbfc
`endif

// [common/pmc_pkg.sv]
package pmc_pkg;
    // Sequencer phase.
    typedef enum logic {FSM_IDLE, FSM_SWITCH} pmc_fsm_t;

    // Clock, oscillator and power enables driven to the chip.
    typedef struct packed {
        logic core_clk;
        logic [7:0] periph_clk;
        logic periph_slow;
        logic xosc;
        logic firc;
        logic sirc;
        logic pll;
        logic flash;
        logic main_reg;
        logic main_pwr;
        logic ram_all;
        logic rtc;
        logic pwt;
    } pmc_ctrl_t;

    // Ready indications from the analog resources.
    typedef struct packed {
        logic xosc_ok;
        logic firc_ok;
        logic sirc_ok;
        logic pll_ok;
        logic flash_ok;
        logic reg_ok;
    } pmc_stable_t;

    // Whole module state.
    typedef struct packed {
        pmc_fsm_t fsm;
        logic [3:0] mode;
        logic [3:0] tgt;
        logic [3:0] prev_run;
        logic [3:0] ret_mode;
        logic [3:0][31:0] run_cfg;
        logic [31:0] default_run_mode_cfg;
        logic [31:0] halt_cfg;
        logic [31:0] stop_cfg;
        logic [31:0] stby_cfg;
        logic [17:0] wake_en;
        logic [19:0] wake_flag;
        logic [17:0] pin_q;
        logic nmi_en;
        logic [1:0] nmi_type;
        logic nmi_q;
        logic nmi_crit;
        logic mce_pulse;
        logic mce_held;
        logic boot_pend;
        logic err;
        pmc_ctrl_t ctrl;
        logic [31:0] prdata;
    } pmc_state_t;
endpackage

// [dv/pmc_checker.sv]
`timescale 1ns/1ps
`include "pmc_defines.svh"

// Pin-level checks of the controller.
module pmc_checker #(
    parameter int ADDR_W = 12
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register bus.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Mode and enables.
    input wire pmc_pkg::pmc_ctrl_t ctrl,
    input wire logic [3:0] mode,
    input wire logic busy,
    input wire logic boot_present,
    input wire logic boot_run,
    input wire logic irq_pending,
    // Interrupt path.
    input wire logic nmi_pin,
    input wire logic core_crit_en,
    input wire logic nmi_crit_irq,
    input wire logic nmi_mce_irq,
    input wire logic nmi_pin_lock
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Access phase; interrupt setup write.
    wire acc = psel && penable;
    wire nmi_wr = acc && pwrite && paddr == `PMC_OFS_NMI_CFG;
    // Two unclearing machine-check cycles mark the held type.
    sequence mce_held_s;
        nmi_mce_irq ##1 (nmi_mce_irq && !nmi_wr);
    endsequence
    // A mode change closes a switch.
    chk_mode_commit: assert property ($changed(mode) |-> $past(busy))
        else $error("mode changed without a switch in flight");
    chk_wait_core: assert property (mode == `PMC_MODE_WAIT && !busy |-> !ctrl.core_clk)
        else $error("core clock runs in wait");
    chk_stop_pll: assert property (mode == `PMC_MODE_STOP && !busy |->
        !ctrl.pll && ctrl.periph_clk == 8'h00) else $error("pll or peripherals on in stop");
    chk_boot_default_run_mode: assert property (boot_run |-> boot_present && mode == `PMC_MODE_DEFAULT_RUN_MODE)
        else $error("boot assist outside default run");
    chk_wake_fast: assert property ((mode == `PMC_MODE_WAIT || mode == `PMC_MODE_HALT)
        && !busy && irq_pending |=> busy) else $error("no wake on interrupt");
    chk_nmi_lock: assert property (nmi_wr && pwdata[0] |=> nmi_pin_lock)
        else $error("pin not locked after enable");
    chk_lock_keep: assert property (nmi_pin_lock |=> nmi_pin_lock)
        else $error("pin lock dropped");
    chk_crit_gate: assert property (nmi_crit_irq |-> $past(core_crit_en) && $past(nmi_pin))
        else $error("critical interrupt not gated");
    chk_mce_held: assert property (mce_held_s |=> nmi_mce_irq)
        else $error("held machine check dropped");
    chk_unmapped_err: assert property (acc && paddr > `PMC_OFS_WAKE_RET |-> pslverr && pready)
        else $error("unmapped access not refused");
endmodule

bind pmc_power_mode_controller pmc_checker #(.ADDR_W(ADDR_W)) pmc_checker_i (.*);

// [dv/tb_power_mode_controller.sv]
`timescale 1ns/1ps
`include "pmc_defines.svh"

// Bench; reads queue expected words.
module tb_power_mode_controller;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, busy, boot_run, nmi_crit_irq, nmi_mce_irq, nmi_pin_lock;
    logic [3:0] mode;
    pmc_pkg::pmc_ctrl_t ctrl;
    pmc_pkg::pmc_stable_t stable = '1;
    // Boot helper always fitted.
    logic boot_present = 1'b1;
    logic irq_pending = 1'b0, pwt_evt = 1'b0, rtc_evt = 1'b0;
    logic nmi_pin = 1'b0, core_crit_en = 1'b0;
    logic [17:0] wake_pin = 18'h0;
    int bad_count = 0, checks_done = 0, seed = 89;
    logic [32:0] exp_q[$];
    logic [31:0] cfg[4];

    // Free-running clock at 125 MHz.
    always #4 ref_clk = ~ref_clk;

    pmc_power_mode_controller #(.ADDR_W(12)) pmc_power_mode_controller_i (.*);

    // Compare; unknown never matches.
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    // Verdict and end of run.
    task automatic end_of_test();
        if (bad_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One transfer; the idle edge ends it.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Reads queue word and refusal.
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back({a > `PMC_OFS_WAKE_RET, e});
        apb(1'b0, a, 32'h0);
    endtask

    // Bounded wait for a committed mode.
    task automatic waitm(input logic [3:0] m);
        int n = 0;
        while (mode !== m && n < 40) begin
            @(posedge ref_clk);
            n++;
        end
        check("mode", {28'h0, mode}, {28'h0, m});
    endtask

    task automatic sw(input logic [3:0] m);
        apb(1'b1, `PMC_OFS_MODE_CTL, {28'h0, m});
        waitm(m);
    endtask

    task automatic rst();
        rst_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
    endtask

    // Monitor: a read pops the oldest note.
    always @(posedge ref_clk) begin
        if (psel && penable && !pwrite && exp_q.size() > 0) begin
            check("prdata", prdata, exp_q[0][31:0]);
            check("pslverr", {31'h0, pslverr}, {31'h0, exp_q[0][32]});
            void'(exp_q.pop_front());
        end
    end

    // Watchdog well past the run length.
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        end_of_test();
    end

    initial begin
        logic [31:0] r;
        int k;
        int cnt;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd(`PMC_OFS_MODE_STAT, 32'h40);
        check("boot_run", boot_run, 1'b1);
        for (k = 0; k < 4; k++) rd(12'(`PMC_OFS_RUN_CFG0 + 4 * k), `PMC_RST_RUN_CFG);
        rd(`PMC_OFS_DEFAULT_RUN_MODE_CFG, `PMC_RST_RUN_CFG);
        rd(`PMC_OFS_HALT_CFG, `PMC_RST_HALT_CFG);
        rd(`PMC_OFS_STOP_CFG, `PMC_RST_STOP_CFG);
        rd(`PMC_OFS_STBY_CFG, `PMC_RST_STBY_CFG);
        rd(12'h040, 32'h0);
        apb(1'b1, 12'h040, 32'hffff_ffff);
        // Random word per user run; run 0 asks for the pll.
        for (k = 0; k < 4; k++) begin
            r = $random(seed);
            cfg[k] = {16'h0000, r[15:8], 8'h37 | {4'h0, r[0] | (k == 0), 3'h0}};
            apb(1'b1, 12'(`PMC_OFS_RUN_CFG0 + 4 * k), cfg[k]);
            sw(4'(k + 1));
            check("periph", ctrl.periph_clk, cfg[k][15:8]);
            check("pll", ctrl.pll, cfg[k][3]);
        end
        // Unready pll holds the old mode.
        stable.pll_ok <= 1'b0;
        apb(1'b1, `PMC_OFS_MODE_CTL, 32'h1);
        repeat (4) @(posedge ref_clk);
        check("held", {busy, mode}, 5'h14);
        stable.pll_ok <= 1'b1;
        waitm(4'h1);
        apb(1'b1, `PMC_OFS_MODE_CTL, 32'h9);
        rd(`PMC_OFS_MODE_STAT, 32'h61);
        apb(1'b1, `PMC_OFS_MODE_STAT, 32'h20);
        apb(1'b1, `PMC_OFS_WAKE_RET, 32'h2);
        sw(`PMC_MODE_WAIT);
        check("core", ctrl.core_clk, 1'b0);
        check("wperiph", ctrl.periph_clk, cfg[0][15:8]);
        apb(1'b1, `PMC_OFS_MODE_CTL, 32'h2);
        rd(`PMC_OFS_MODE_STAT, 32'h65);
        apb(1'b1, `PMC_OFS_MODE_STAT, 32'h20);
        irq_pending <= 1'b1;
        @(posedge ref_clk);
        irq_pending <= 1'b0;
        waitm(4'h2);
        // Halt with reset setup, then pll on, flash and regulator off.
        for (k = 0; k < 2; k++) begin
            if (k == 1) apb(1'b1, `PMC_OFS_HALT_CFG, 32'h0003_ff4a);
            sw(`PMC_MODE_HALT);
            check("hcore", ctrl.core_clk, 1'b0);
            check("hpll", ctrl.pll, k[0]);
            check("hoff", {ctrl.flash, ctrl.main_reg, ctrl.periph_slow}, {!k[0], !k[0], k[0]});
            irq_pending <= 1'b1;
            @(posedge ref_clk);
            irq_pending <= 1'b0;
            waitm(4'h2);
        end
        // Stop, oscillator off then kept; each timer wakes.
        for (k = 0; k < 2; k++) begin
            if (k == 1) apb(1'b1, `PMC_OFS_STOP_CFG, 32'h0003_ff0f);
            sw(`PMC_MODE_STOP);
            check("spll", {ctrl.pll, ctrl.periph_clk, ctrl.main_pwr}, 10'h001);
            check("sxosc", ctrl.xosc, k[0]);
            check("srtc", {ctrl.rtc, ctrl.pwt}, 2'b11);
            check("src", {ctrl.firc, ctrl.sirc}, 2'b11);
            if (k == 1) rtc_evt <= 1'b1;
            else pwt_evt <= 1'b1;
            @(posedge ref_clk);
            rtc_evt <= 1'b0;
            pwt_evt <= 1'b0;
            waitm(4'h2);
            rd(`PMC_OFS_WAKE_FLAG, k == 1 ? 32'h0008_0000 : 32'h0004_0000);
            apb(1'b1, `PMC_OFS_WAKE_FLAG, 32'h000f_ffff);
        end
        // Standby; one random armed pin wakes it.
        apb(1'b1, `PMC_OFS_WAKE_EN, 32'h0003_ffff);
        apb(1'b1, `PMC_OFS_STBY_CFG, 32'h0007_0004);
        sw(`PMC_MODE_STBY);
        check("sby", {ctrl.ram_all, ctrl.sirc, ctrl.main_pwr, ctrl.core_clk}, 4'hc);
        k = {$random(seed)} % 18;
        wake_pin <= 18'(1) << k;
        @(posedge ref_clk);
        wake_pin <= 18'h0;
        waitm(`PMC_MODE_DEFAULT_RUN_MODE);
        rd(`PMC_OFS_MODE_STAT, 32'h40);
        rd(`PMC_OFS_WAKE_FLAG, 32'(1) << k);
        // Each interrupt type after reset; setup freezes.
        for (k = 0; k < 3; k++) begin
            rst();
            apb(1'b1, `PMC_OFS_NMI_CFG, {29'h0, 2'(k), 1'b1});
            apb(1'b1, `PMC_OFS_NMI_CFG, 32'h0);
            rd(`PMC_OFS_NMI_CFG, {29'h0, 2'(k), 1'b1});
            check("lock", nmi_pin_lock, 1'b1);
            nmi_pin <= 1'b1;
            cnt = 0;
            repeat (6) begin
                @(posedge ref_clk);
                cnt += nmi_mce_irq;
            end
            check("crit0", nmi_crit_irq, 1'b0);
            if (k == 1) check("pulse", cnt, 1);
            check("held", nmi_mce_irq, k == 2);
            core_crit_en <= 1'b1;
            repeat (3) @(posedge ref_clk);
            check("crit1", nmi_crit_irq, k == 0);
            nmi_pin <= 1'b0;
            core_crit_en <= 1'b0;
            apb(1'b1, `PMC_OFS_NMI_CFG, 32'h8);
            check("clr", nmi_mce_irq, 1'b0);
        end
        end_of_test();
    end
endmodule

// [logic/pmc_power_mode_controller.sv]
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "pmc_defines.svh"

module pmc_power_mode_controller #(
    parameter int ADDR_W = 12
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Resource readiness.
    input wire pmc_pkg::pmc_stable_t stable,
    // Enables to clocks, oscillators and supplies.
    output pmc_pkg::pmc_ctrl_t ctrl,
    // Mode status.
    output logic [3:0] mode,
    output logic busy,
    // Boot assist program.
    input wire logic boot_present,
    output logic boot_run,
    // Wakeup sources.
    input wire logic irq_pending,
    input wire logic [17:0] wake_pin,
    input wire logic pwt_evt,
    input wire logic rtc_evt,
    // Non-maskable interrupt.
    input wire logic nmi_pin,
    input wire logic core_crit_en,
    output logic nmi_crit_irq,
    output logic nmi_mce_irq,
    output logic nmi_pin_lock
);

    // The decode reads twelve address bits.
    initial begin
        if (ADDR_W < 12 || ADDR_W > 32) begin
            $error("ADDR_W out of range");
        end
    end

    // Present and next module state.
    pmc_pkg::pmc_state_t st_r;
    pmc_pkg::pmc_state_t st_nxt;

    // True for the default or a user run mode.
    function automatic logic is_run(input logic [3:0] m);
        is_run = (m <= `PMC_MODE_RUN3);
    endfunction

    // Offset decode for read, write and error paths.
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        logic [11:0] o;
        o = a[11:0];
        addr_ok = (a[1:0] == 2'h0) && (o <= `PMC_OFS_WAKE_RET);
    endfunction

    // Configuration word of a mode.
    function automatic logic [31:0] cfg_of(input pmc_pkg::pmc_state_t s,
                                           input logic [3:0] m);
        logic [3:0] r;
        r = is_run(m) ? m : (is_run(s.mode) ? s.mode : s.prev_run);
        unique case (m)
            `PMC_MODE_HALT: cfg_of = s.halt_cfg;
            `PMC_MODE_STOP: cfg_of = s.stop_cfg;
            `PMC_MODE_STBY: cfg_of = s.stby_cfg;
            default: begin
                // Wait reuses the run setup it was entered from.
                if (r == `PMC_MODE_DEFAULT_RUN_MODE) begin
                    cfg_of = s.default_run_mode_cfg;
                end else begin
                    cfg_of = s.run_cfg[2'(r - `PMC_MODE_RUN0)]; // see RULE2
                end
            end
        endcase
    endfunction

    // Mode and word to enables.
    function automatic pmc_pkg::pmc_ctrl_t ctrl_of(input logic [3:0] m,
                                                   input logic [31:0] c);
        pmc_pkg::pmc_ctrl_t k;
        k.core_clk = 1'b1;
        k.periph_clk = c[`PMC_CFG_PCLK_LO +: 8]; // see RULE1
        k.periph_slow = c[`PMC_CFG_SLOW];
        k.xosc = c[`PMC_CFG_XOSC];
        k.firc = c[`PMC_CFG_FIRC];
        k.sirc = c[`PMC_CFG_SIRC];
        k.pll = c[`PMC_CFG_PLL];
        k.flash = c[`PMC_CFG_FLASH];
        k.main_reg = 1'b1;
        k.main_pwr = 1'b1;
        k.ram_all = 1'b1;
        k.rtc = c[`PMC_CFG_RTC];
        k.pwt = c[`PMC_CFG_PWT];
        if (m == `PMC_MODE_WAIT) begin
            // Only the core stops; peripherals keep the run gating at full speed.
            k.core_clk = 1'b0; // see RULE6
            k.periph_slow = 1'b0; // see RULE6
        end else if (m == `PMC_MODE_HALT) begin
            // Halt may also drop the regulator; PLL and flash follow the word.
            k.core_clk = 1'b0; // see RULE8
            k.main_reg = c[`PMC_CFG_MREG]; // see RULE9
            k.pll = c[`PMC_CFG_PLL]; // see RULE10
        end else if (m == `PMC_MODE_STOP) begin
            k.core_clk = 1'b0; // see RULE11
            k.periph_clk = 8'h00; // see RULE11
            k.periph_slow = 1'b0;
            k.pll = 1'b0; // see RULE11
            // Oscillators and timers stay only where the word keeps them.
            k.xosc = c[`PMC_CFG_XOSC]; // see RULE12
            k.firc = c[`PMC_CFG_FIRC]; // see RULE14
            k.sirc = c[`PMC_CFG_SIRC]; // see RULE14
            k.rtc = c[`PMC_CFG_RTC]; // see RULE13
            k.pwt = c[`PMC_CFG_PWT]; // see RULE13
        end else if (m == `PMC_MODE_STBY) begin
            // Only the island survives: slow RC and timers where the word keeps them, and retained RAM.
            k.core_clk = 1'b0;
            k.periph_clk = 8'h00;
            k.periph_slow = 1'b0;
            k.xosc = 1'b0;
            k.firc = 1'b0;
            k.pll = 1'b0;
            k.flash = 1'b0;
            k.main_reg = 1'b0;
            k.main_pwr = 1'b0; // see RULE15
            k.ram_all = c[`PMC_CFG_RAM_ALL]; // see RULE15
        end
        ctrl_of = k;
    endfunction

    // Every requested resource reports ready.
    function automatic logic all_ok(input pmc_pkg::pmc_ctrl_t k,
                                    input pmc_pkg::pmc_stable_t s);
        all_ok = (!k.xosc || s.xosc_ok) && (!k.firc || s.firc_ok) &&
                 (!k.sirc || s.sirc_ok) && (!k.pll || s.pll_ok) &&
                 (!k.flash || s.flash_ok) && (!k.main_reg || s.reg_ok);
    endfunction

    // Register read mux.
    function automatic logic [31:0] rd_word(input pmc_pkg::pmc_state_t s,
                                            input logic [11:0] o);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (o)
            `PMC_OFS_MODE_CTL: v[3:0] = s.tgt;
            `PMC_OFS_MODE_STAT: begin
                v[3:0] = s.mode;
                v[`PMC_STAT_BUSY] = (s.fsm == pmc_pkg::FSM_SWITCH);
                v[`PMC_STAT_ERR] = s.err;
                v[`PMC_STAT_BOOT] = s.boot_pend;
            end
            `PMC_OFS_DEFAULT_RUN_MODE_CFG: v = s.default_run_mode_cfg;
            `PMC_OFS_HALT_CFG: v = s.halt_cfg;
            `PMC_OFS_STOP_CFG: v = s.stop_cfg;
            `PMC_OFS_STBY_CFG: v = s.stby_cfg;
            `PMC_OFS_WAKE_EN: v[17:0] = s.wake_en;
            `PMC_OFS_WAKE_FLAG: v[19:0] = s.wake_flag;
            `PMC_OFS_NMI_CFG: v[2:0] = {s.nmi_type, s.nmi_en};
            `PMC_OFS_WAKE_RET: v[3:0] = s.ret_mode;
            default: begin
                // The four run words sit in a row.
                if (o >= `PMC_OFS_RUN_CFG0 && o < `PMC_OFS_DEFAULT_RUN_MODE_CFG) begin
                    v = s.run_cfg[2'((o - `PMC_OFS_RUN_CFG0) >> 2)];
                end
            end
        endcase
        rd_word = v;
    endfunction

    // Next-state logic for bus, sequencer, wakeup and interrupt routing.
    always_comb begin
        logic wr;
        logic [11:0] o;
        logic [3:0] req;
        logic req_ok;
        logic [17:0] edges;
        logic wake_any;
        logic wake;
        logic [3:0] back;
        wr = 1'b0;
        o = paddr[11:0];
        req = pwdata[3:0];
        req_ok = 1'b0;
        edges = 18'h00000;
        wake_any = 1'b0;
        wake = 1'b0;
        back = `PMC_MODE_DEFAULT_RUN_MODE;
        st_nxt = st_r;
        wr = psel && penable && pwrite && addr_ok(paddr);

        // Read data is captured at setup, held through access.
        if (psel && !penable) begin
            st_nxt.prdata = addr_ok(paddr) ? rd_word(st_r, o) : 32'h0000_0000;
        end

        // Plain configuration writes.
        if (wr) begin
            if (o >= `PMC_OFS_RUN_CFG0 && o < `PMC_OFS_DEFAULT_RUN_MODE_CFG) begin
                st_nxt.run_cfg[2'((o - `PMC_OFS_RUN_CFG0) >> 2)] = pwdata; // see RULE2
            end
            if (o == `PMC_OFS_DEFAULT_RUN_MODE_CFG) begin
                st_nxt.default_run_mode_cfg = pwdata;
            end
            if (o == `PMC_OFS_HALT_CFG) begin
                st_nxt.halt_cfg = pwdata;
            end
            if (o == `PMC_OFS_STOP_CFG) begin
                st_nxt.stop_cfg = pwdata;
            end
            if (o == `PMC_OFS_STBY_CFG) begin
                st_nxt.stby_cfg = pwdata;
            end
            if (o == `PMC_OFS_WAKE_EN) begin
                st_nxt.wake_en = pwdata[17:0]; // see RULE18
            end
            if (o == `PMC_OFS_WAKE_RET) begin
                st_nxt.ret_mode = pwdata[3:0];
            end
            if (o == `PMC_OFS_WAKE_FLAG) begin
                st_nxt.wake_flag = st_r.wake_flag & ~pwdata[19:0];
            end
            if (o == `PMC_OFS_NMI_CFG) begin
                // Once enabled the setup is frozen until reset.
                if (!st_r.nmi_en) begin
                    st_nxt.nmi_en = pwdata[0]; // see RULE19
                    st_nxt.nmi_type = pwdata[2:1]; // see RULE20
                end
                if (pwdata[`PMC_NMI_CLR_HOLD]) begin
                    st_nxt.mce_held = 1'b0;
                end
            end
            if (o == `PMC_OFS_MODE_STAT && pwdata[`PMC_STAT_ERR]) begin
                st_nxt.err = 1'b0;
            end
        end

        // Wakeup pins flag rising edges; a new event beats a clear.
        edges = wake_pin & ~st_r.pin_q;
        st_nxt.pin_q = wake_pin;
        st_nxt.wake_flag[17:0] = st_nxt.wake_flag[17:0] | (edges & st_r.wake_en); // see RULE18
        if (pwt_evt && st_r.ctrl.pwt) begin
            st_nxt.wake_flag[`PMC_FLAG_PWT] = 1'b1;
        end
        if (rtc_evt && st_r.ctrl.rtc) begin
            st_nxt.wake_flag[`PMC_FLAG_RTC] = 1'b1;
        end
        wake_any = |(st_r.wake_flag[17:0] & st_r.wake_en) |
                   st_r.wake_flag[`PMC_FLAG_PWT] | st_r.wake_flag[`PMC_FLAG_RTC]; // see RULE17

        // Which low-power modes each source may end.
        unique case (st_r.mode)
            `PMC_MODE_WAIT: wake = irq_pending; // see RULE7
            `PMC_MODE_HALT: wake = irq_pending || wake_any;
            `PMC_MODE_STOP: wake = irq_pending || wake_any;
            `PMC_MODE_STBY: wake = wake_any; // see RULE17
            default: wake = 1'b0;
        endcase
        back = is_run(st_r.ret_mode) ? st_r.ret_mode : st_r.prev_run; // see RULE24
        if (st_r.mode == `PMC_MODE_STBY) begin
            back = `PMC_MODE_DEFAULT_RUN_MODE; // see RULE24
        end

        // Any request is taken only from a running mode.
        req_ok = (req <= `PMC_MODE_STBY) && is_run(st_r.mode); // see RULE4

        // Sequencer: enables first, commit once confirmed.
        unique case (st_r.fsm)
            pmc_pkg::FSM_IDLE: begin
                if (wr && o == `PMC_OFS_MODE_CTL) begin
                    if (pwdata[`PMC_CTL_BOOT_DONE]) begin
                        st_nxt.boot_pend = 1'b0;
                    end
                    if (req_ok) begin
                        st_nxt.tgt = req;
                        st_nxt.fsm = pmc_pkg::FSM_SWITCH;
                        st_nxt.ctrl = ctrl_of(req, cfg_of(st_r, req)); // see RULE3
                        if (is_run(st_r.mode)) begin
                            st_nxt.prev_run = st_r.mode;
                        end
                    end else begin
                        st_nxt.err = 1'b1;
                    end
                end else if (wake) begin
                    st_nxt.tgt = back;
                    st_nxt.fsm = pmc_pkg::FSM_SWITCH;
                    st_nxt.ctrl = ctrl_of(back, cfg_of(st_r, back)); // see RULE9
                    if (st_r.mode == `PMC_MODE_STBY) begin
                        st_nxt.boot_pend = 1'b1;
                    end
                end
            end
            pmc_pkg::FSM_SWITCH: begin
                // Requests made while switching are refused.
                if (wr && o == `PMC_OFS_MODE_CTL) begin
                    st_nxt.err = 1'b1;
                end
                if (all_ok(st_r.ctrl, stable)) begin
                    st_nxt.mode = st_r.tgt; // see RULE23
                    st_nxt.fsm = pmc_pkg::FSM_IDLE;
                end
            end
        endcase

        // Non-maskable interrupt routing by type.
        st_nxt.nmi_q = nmi_pin;
        st_nxt.nmi_crit = st_r.nmi_en && (st_r.nmi_type == 2'h0) &&
                          nmi_pin && core_crit_en; // see RULE20
        st_nxt.mce_pulse = st_r.nmi_en && (st_r.nmi_type == 2'h1) &&
                           nmi_pin && !st_r.nmi_q; // see RULE21
        if (st_r.nmi_en && st_r.nmi_type == 2'h2 && nmi_pin) begin
            st_nxt.mce_held = 1'b1; // see RULE22
        end
    end

    // State register; reset lands in default run.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.fsm <= pmc_pkg::FSM_IDLE;
            st_r.mode <= `PMC_MODE_DEFAULT_RUN_MODE; // see RULE4
            st_r.tgt <= `PMC_MODE_DEFAULT_RUN_MODE;
            st_r.prev_run <= `PMC_MODE_DEFAULT_RUN_MODE;
            st_r.ret_mode <= `PMC_MODE_DEFAULT_RUN_MODE;
            st_r.run_cfg <= {4{`PMC_RST_RUN_CFG}};
            st_r.default_run_mode_cfg <= `PMC_RST_RUN_CFG;
            st_r.halt_cfg <= `PMC_RST_HALT_CFG;
            st_r.stop_cfg <= `PMC_RST_STOP_CFG;
            st_r.stby_cfg <= `PMC_RST_STBY_CFG;
            st_r.boot_pend <= 1'b1;
            st_r.ctrl <= `PMC_RST_CTRL;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Ports.
    assign prdata = st_r.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok(paddr);
    assign ctrl = st_r.ctrl;
    assign mode = st_r.mode;
    assign busy = (st_r.fsm == pmc_pkg::FSM_SWITCH);
    assign boot_run = st_r.boot_pend && boot_present &&
                      (st_r.mode == `PMC_MODE_DEFAULT_RUN_MODE); // see RULE5
    assign nmi_crit_irq = st_r.nmi_crit;
    assign nmi_mce_irq = st_r.mce_pulse || st_r.mce_held;
    assign nmi_pin_lock = st_r.nmi_en; // see RULE19

endmodule
